// file: src/sest_timer.sv
`timescale 1ns/1ps
`include "sest_cfg.svh"

// standby exit settling timer with the divided count clocks for on-chip timers
module sest_timer (
  input wire logic SYS_CLK, // 40 MHz system clock
  input wire logic RESET, // async reset, active high
  input wire logic SEL_WE, // write strobe for settling select field
  input wire logic [2:0] SEL_WDATA, // new settling select code
  input wire logic SLEEP_REQ, // sleep instruction with standby chosen, pulse
  input wire logic WAKE_IRQ_PIN, // wake interrupt from pin, async level
  input wire logic [3:0] TMR_CKS, // timer count clock: clock / 2^(CKS+1) for CKS 0..10, no count clock for CKS 11..15
  output logic [2:0] SEL_RDATA, // current settling select code
  output logic OSC_EN, // oscillator enable
  output logic CLK_EN, // internal clock enable
  output logic SETTLING, // settling count in progress
  output logic RESUME, // one-cycle pulse when execution resumes
  output logic TMR_TICK, // count enable for an on-chip timer
  output sest_pkg::sest_status_t STATUS // bundled status
);

  //--------------------------------------------------------------
  // settling select field
  //--------------------------------------------------------------

  logic [2:0] settle_sel;

  // field keeps its value through software standby, cleared only by reset
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      settle_sel <= `SEST_SEL_RESET;
    end else if (SEL_WE) begin
      settle_sel <= SEL_WDATA;
    end
  end

  assign SEL_RDATA = settle_sel;

  // map code to state count; codes 110/111 fall to the longest wait
  function automatic logic [`SEST_CNT_W-1:0] sel_states(input logic [2:0] sel);
    unique case (sel)
      `SEST_SEL_8K: sel_states = `SEST_STATES_8K;
      `SEST_SEL_16K: sel_states = `SEST_STATES_16K;
      `SEST_SEL_32K: sel_states = `SEST_STATES_32K;
      `SEST_SEL_64K: sel_states = `SEST_STATES_64K;
      `SEST_SEL_1K: sel_states = `SEST_STATES_1K;
      default: sel_states = `SEST_STATES_128K;
    endcase
  endfunction

  //--------------------------------------------------------------
  // wake input synchroniser
  //--------------------------------------------------------------

  logic [2:0] wake_sync;
  logic wake_lvl;

  // three stages; level updates once stages two and three agree
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      wake_sync <= 3'h0;
      wake_lvl <= 1'b0;
    end else begin
      wake_sync <= {wake_sync[1:0], WAKE_IRQ_PIN};
      if (wake_sync[1] == wake_sync[2]) begin
        wake_lvl <= wake_sync[2];
      end
    end
  end

  //--------------------------------------------------------------
  // standby state machine
  //--------------------------------------------------------------

  sest_pkg::sest_state_t state;
  sest_pkg::sest_state_t next_state;
  logic [`SEST_CNT_W-1:0] cnt;
  logic [`SEST_CNT_W-1:0] next_cnt;
  logic cnt_done;

  assign cnt_done = (cnt == `SEST_CNT_W'(1));

  // any code is taken as is; the count length is the only difference
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      sest_pkg::SEST_RUN: begin
        if (SLEEP_REQ) begin
          next_state = sest_pkg::SEST_STOPPED;
        end
      end
      sest_pkg::SEST_STOPPED: begin
        if (wake_lvl) begin
          next_state = sest_pkg::SEST_SETTLE;
          next_cnt = sel_states(settle_sel);
        end
      end
      sest_pkg::SEST_SETTLE: begin
        next_cnt = cnt - `SEST_CNT_W'(1);
        if (cnt_done) begin
          next_state = sest_pkg::SEST_RUN;
        end
      end
      default: begin
        next_state = sest_pkg::SEST_RUN;
      end
    endcase
  end

  // state and settling counter
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= sest_pkg::SEST_RUN;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // resume pulse registered on leaving the settling state
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      RESUME <= 1'b0;
    end else begin
      RESUME <= (state == sest_pkg::SEST_SETTLE) && cnt_done;
    end
  end

  assign OSC_EN = (state != sest_pkg::SEST_STOPPED);
  assign CLK_EN = (state == sest_pkg::SEST_RUN);
  assign SETTLING = (state == sest_pkg::SEST_SETTLE);
  assign STATUS = '{clk_en: CLK_EN, osc_en: OSC_EN, settling: SETTLING};

  //--------------------------------------------------------------
  // timer count clock
  //--------------------------------------------------------------

  logic [`SEST_PRESC_W-1:0] tick;
  logic slow_clk;
  logic sel_1k;

  sest_prescaler u_presc (
    .clk(SYS_CLK),
    .rst(RESET),
    .run(CLK_EN),
    .tick(tick)
  );

  // ratios beyond clock/1024 are lost while the 1024 setting is held
  assign slow_clk = (TMR_CKS > 4'h9);
  assign sel_1k = (settle_sel == `SEST_SEL_1K);
  assign TMR_TICK = (TMR_CKS < 4'hB) ? (tick[TMR_CKS] && !(slow_clk && sel_1k)) : 1'b0;

endmodule

// file: src/sest_cfg.svh
// Functional notes
// - codes 000..100 select 8192, 16384, 32768, 65536, 131072 settling states.
// - code 101 selects a 1024-state wait, intended for an external clock.
// - with an external clock any code is accepted and exit works.
// - under the 1024 setting, timers slower than clock/1024 miss count-ups.
`ifndef SEST_CFG_SVH
`define SEST_CFG_SVH

`define SEST_SEL_W 3
`define SEST_CNT_W 18
`define SEST_SEL_8K 3'h0
`define SEST_SEL_16K 3'h1
`define SEST_SEL_32K 3'h2
`define SEST_SEL_64K 3'h3
`define SEST_SEL_128K 3'h4
`define SEST_SEL_1K 3'h5
`define SEST_STATES_8K 18'h02000
`define SEST_STATES_16K 18'h04000
`define SEST_STATES_32K 18'h08000
`define SEST_STATES_64K 18'h10000
`define SEST_STATES_128K 18'h20000
`define SEST_STATES_1K 18'h00400
`define SEST_SEL_RESET 3'h0
`define SEST_PRESC_W 11
`define SEST_PRESC_1024 11'h3FF

`endif

// file: src/sest_pkg.sv
package sest_pkg;

  // settling timer states; run -> stopped and stopped -> settling change one bit, settling -> run changes two
  typedef enum logic [1:0] {
    SEST_RUN = 2'b00,
    SEST_STOPPED = 2'b01,
    SEST_SETTLE = 2'b11
  } sest_state_t;

  // status seen by the rest of the chip
  typedef struct packed {
    logic clk_en;
    logic osc_en;
    logic settling;
  } sest_status_t;

endpackage

// file: src/sest_prescaler.sv
`timescale 1ns/1ps
`include "sest_cfg.svh"

// divider, held while the internal clock is stopped, giving clock/2 .. clock/2048 tick pulses
module sest_prescaler (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // counts only while internal clock runs
  output logic [`SEST_PRESC_W-1:0] tick // one-cycle pulse per divide ratio
);

  logic [`SEST_PRESC_W-1:0] cnt;
  logic [`SEST_PRESC_W-1:0] next_cnt;

  assign next_cnt = cnt + `SEST_PRESC_W'(1);

  // bit k pulses when the low k+1 bits wrap
  genvar k;
  generate
    for (k = 0; k < `SEST_PRESC_W; k = k + 1) begin : g_tick
      assign tick[k] = run && (&cnt[k:0]);
    end
  endgenerate

  // counter advances each running cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (run) begin
      cnt <= next_cnt;
    end
  end

endmodule

// file: verification/sest_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// settling timer port checker
// ----------------------------------------
module sest_checker (
  input wire logic SYS_CLK, // system clock
  input wire logic RESET, // async reset
  input wire logic [2:0] SEL_RDATA, // settling code
  input wire logic [3:0] TMR_CKS, // timer clock select
  input wire logic OSC_EN, // oscillator enable
  input wire logic CLK_EN, // clock enable
  input wire logic SETTLING, // counting
  input wire logic RESUME, // resume pulse
  input wire logic SLEEP_REQ, // standby request
  input wire logic TMR_TICK // timer tick
);
  logic [17:0] cnt;
  wire [17:0] n;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // expected settling length for the current code
  assign n = (SEL_RDATA == 3'h5) ? 18'h00400 :
    (18'h02000 << ((SEL_RDATA > 3'h4) ? 3'h4 : SEL_RDATA));
  // cycles spent settling so far
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) cnt <= 18'h00000;
    else cnt <= SETTLING ? cnt + 18'h00001 : 18'h00000;
  end
  AST_SLEEP: assert property (SLEEP_REQ && CLK_EN |=> !CLK_EN && !OSC_EN)
    else $error("sleep did not stop clocks");
  AST_START: assert property ($rose(SETTLING) |-> !$past(OSC_EN))
    else $error("settling began outside standby");
  AST_OSC: assert property (SETTLING |-> OSC_EN && !CLK_EN)
    else $error("clock ran while settling");
  AST_RUN: assert property (CLK_EN |-> OSC_EN && !SETTLING)
    else $error("running with oscillator off");
  AST_RESUME: assert property ($fell(SETTLING) |-> RESUME && CLK_EN)
    else $error("no resume after settling");
  AST_PULSE: assert property (RESUME |=> !RESUME)
    else $error("resume longer than one cycle");
  AST_LEN: assert property ($fell(SETTLING) |-> cnt == n)
    else $error("wrong settling length");
  AST_TICK: assert property (SEL_RDATA == 3'h5 && TMR_CKS >= 4'hA |-> !TMR_TICK)
    else $error("slow timer ticked under short wait");
  cover property ($fell(SETTLING));
  cover property ($rose(SETTLING) && SEL_RDATA == 3'h5);
  cover property (TMR_TICK && SEL_RDATA == 3'h5);
endmodule

// file: verification/standby_exit_settling_timer_tb_top.sv
`timescale 1ns/1ps
module standby_exit_settling_timer_tb_top;
  logic SYS_CLK, RESET, SEL_WE, SLEEP_REQ, WAKE_IRQ_PIN;
  logic [2:0] SEL_WDATA, SEL_RDATA;
  logic [3:0] TMR_CKS;
  logic OSC_EN, CLK_EN, SETTLING, RESUME, TMR_TICK;
  sest_pkg::sest_status_t STATUS;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  sest_timer dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .SEL_WE(SEL_WE), .SEL_WDATA(SEL_WDATA),
    .SLEEP_REQ(SLEEP_REQ), .WAKE_IRQ_PIN(WAKE_IRQ_PIN), .TMR_CKS(TMR_CKS),
    .SEL_RDATA(SEL_RDATA), .OSC_EN(OSC_EN), .CLK_EN(CLK_EN), .SETTLING(SETTLING),
    .RESUME(RESUME), .TMR_TICK(TMR_TICK), .STATUS(STATUS));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic put_code(input logic [2:0] code);
    @(posedge SYS_CLK);
    SEL_WE <= 1'b1;
    SEL_WDATA <= code;
    @(posedge SYS_CLK);
    SEL_WE <= 1'b0;
    #1 chk(SEL_RDATA, code);
  endtask
  // sleep, wake, and measure the settling length
  // the bench models an external clock, so the crystal minimum does not apply
  task automatic settle(input logic [2:0] code, input logic [31:0] n);
    int k;
    put_code(code);
    @(posedge SYS_CLK);
    SLEEP_REQ <= 1'b1;
    @(posedge SYS_CLK);
    SLEEP_REQ <= 1'b0;
    @(posedge SYS_CLK);
    #1 chk({CLK_EN, OSC_EN}, 0);
    @(posedge SYS_CLK);
    WAKE_IRQ_PIN <= 1'b1;
    k = 0;
    while (SETTLING !== 1'b1 && k < 20) begin
      @(posedge SYS_CLK);
      #1 k++;
    end
    k = 0;
    while (SETTLING === 1'b1) begin
      @(posedge SYS_CLK);
      #1 k++;
    end
    chk(k, n);
    chk({RESUME, CLK_EN}, 3);
    chk(STATUS, 3'h6);
    @(posedge SYS_CLK);
    WAKE_IRQ_PIN <= 1'b0;
    // let the synchronised wake level fall before the next sleep
    repeat (6) @(posedge SYS_CLK);
  endtask
  // count timer ticks over 2048 cycles
  task automatic ticks(input logic [2:0] code, input logic [3:0] cks, input int exp);
    int k;
    put_code(code);
    TMR_CKS <= cks;
    k = 0;
    repeat (2048) begin
      @(posedge SYS_CLK);
      #1 k += TMR_TICK;
    end
    chk(k, exp);
  endtask
  initial begin
    SYS_CLK = 0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    RESET = 1'b1;
    SEL_WE = 1'b0;
    SLEEP_REQ = 1'b0;
    WAKE_IRQ_PIN = 1'b0;
    SEL_WDATA = 3'h0;
    TMR_CKS = 4'h0;
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    settle(3'h5, 1024);
    settle(3'h0, 8192);
    settle(3'h1, 16384);
    settle(3'h2, 32768);
    ticks(3'h5, 4'hA, 0);
    ticks(3'h5, 4'h9, 2);
    ticks(3'h0, 4'hA, 1);
    give_verdict();
  end
endmodule
bind sest_timer sest_checker chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .SEL_RDATA(SEL_RDATA),
  .TMR_CKS(TMR_CKS), .OSC_EN(OSC_EN), .CLK_EN(CLK_EN), .SETTLING(SETTLING),
  .RESUME(RESUME), .SLEEP_REQ(SLEEP_REQ), .TMR_TICK(TMR_TICK));
